/* File: common/pcsr_defines.svh */
// Constants for the pad configuration and supply status register bank.
// Assumes a 40 MHz APB clock and 16-bit registers on 32-bit words.
// Function
// - drive bit one selects partial strength
// - host pull enable bit turns resistor on
// - host pull select one means pull-up
// - phy pull enable bits 3..0 enable resistor
// - phy pull select one means pull-up
// - five pad registers reset to zero
// - bit1 low-voltage flag, bit0 power-on flag
// - reading supply status clears all flags
// - condition detected again sets flag again
// - supply flags never raise the interrupt
// - supply event forces hard-reset, flag kept
// - bit duration holds seven bit count
// - bit duration written only in configuration
// - configuration bit and reset enter configuration
`ifndef PCSR_DEFINES_SVH
`define PCSR_DEFINES_SVH

// Register indices; byte address is four times the index
`define PCSR_IDX_DRIVE 8'h9C
`define PCSR_IDX_HOST_PEN 8'h9E
`define PCSR_IDX_HOST_PSEL 8'hA0
`define PCSR_IDX_PHY_PEN 8'hA2
`define PCSR_IDX_PHY_PSEL 8'hA4
`define PCSR_IDX_SUPPLY 8'hA6
`define PCSR_IDX_BIT_DUR 8'hA8
`define PCSR_IDX_CTRL 8'hB8
`define PCSR_IDX_IRQ_STAT 8'hB9
`define PCSR_IDX_IRQ_MASK 8'hBA

`define PCSR_PAD_RESET 16'h0000
`define PCSR_BIT_DUR_RESET 7'h00
`define PCSR_CTRL_CONFIG_BIT 0
`define PCSR_SUP_LOW_VOLT_BIT 1
`define PCSR_SUP_POWER_ON_BIT 0
`define PCSR_IRQ_BD_REFUSED_BIT 0
`define PCSR_IRQ_CONFIG_ENTER_BIT 1

`define PCSR_CLK_PERIOD_NS 25
`define PCSR_RST_HOLD_NS 200
`define PCSR_RST_HOLD_CYC \
  ((`PCSR_RST_HOLD_NS + `PCSR_CLK_PERIOD_NS - 1) / `PCSR_CLK_PERIOD_NS)

`endif

/* File: common/pcsr_pkg.sv */
// Types shared by the pad configuration register bank.
// Assumes the constants header supplies offsets and timing.
package pcsr_pkg;
  typedef enum logic [0:0] {
    PCSR_CONFIG = 1'b0,
    PCSR_NORMAL = 1'b1
  } pcsr_state_t;
endpackage : pcsr_pkg

/* File: hw/pcsr_regs.sv */
// Pad drive/pull configuration, supply event status, bit duration.
// Assumes an APB3 master on clk and asynchronous regulator event pins.
`timescale 1ns/1ps
`include "pcsr_defines.svh"

module pcsr_regs #(
  parameter int HOST_PINS = 16, // host-side pad count
  parameter int PHY_PINS = 4 // transceiver-side pad count
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst_b, // hard reset, sync, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic low_volt_evt, // regulator low-voltage, async
  input wire logic power_on_evt, // regulator power-on, async
  output logic controller_irq_n, // level interrupt, active low
  output logic int_reset_active, // internal reset in progress
  output logic config_state, // controller in configuration state
  output logic [6:0] microticks_per_bit, // bit duration count
  output logic [PHY_PINS-1:0] phy_drive_partial, // 1 partial strength
  output logic [HOST_PINS-1:0] host_pull_up, // pull-up active
  output logic [HOST_PINS-1:0] host_pull_down, // pull-down active
  output logic [PHY_PINS-1:0] phy_pull_up, // pull-up active
  output logic [PHY_PINS-1:0] phy_pull_down // pull-down active
);

  localparam logic [7:0] RST_HOLD = 8'(`PCSR_RST_HOLD_CYC);

  // Word index times four is the byte address. Unmapped or misaligned
  // addresses answer with pslverr and read zero; writes to them drop.

  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction : hit

  // Pull direction decode, shared by host and transceiver pads
  function automatic logic pull_up_of(input logic en,
      input logic up_sel);
    pull_up_of = en && up_sel;
  endfunction : pull_up_of

  function automatic logic pull_down_of(input logic en,
      input logic up_sel);
    pull_down_of = en && !up_sel;
  endfunction : pull_down_of

  // Keeps the four implemented transceiver bits; reserved ones stay zero
  function automatic logic [15:0] phy_field(input logic [31:0] d);
    phy_field = {12'h000, d[3:0]};
  endfunction : phy_field

  // A 16-bit register as seen on the 32-bit read bus
  function automatic logic [31:0] word16(input logic [15:0] v);
    word16 = {16'h0000, v};
  endfunction : word16

  // Event synchronisers, two flops each; only the second flop is read
  wire [1:0] evt_raw = {low_volt_evt, power_on_evt};
  logic [1:0] evt_meta;
  logic [1:0] evt_sync;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_meta <= 2'b00;
      evt_sync <= 2'b00;
    end else begin
      evt_meta <= evt_raw;
      evt_sync <= evt_meta;
    end
  end

  // Internal reset stretches past the event, same effect as hard reset except on the supply flags.
  // The stretch keeps the host off the bus while the supply settles.
  logic [7:0] hold_cnt;
  wire evt_any = |evt_sync;
  wire hold_busy = (hold_cnt != 8'h00);
  wire int_rst = !rst_b || evt_any || hold_busy;
  wire [7:0] next_hold = evt_any ? RST_HOLD :
                         hold_busy ? hold_cnt - 8'h01 : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold_cnt <= 8'h00;
    end else begin
      hold_cnt <= next_hold;
    end
  end

  // APB decode
  logic [15:0] drive_reg;
  logic [15:0] host_pen;
  logic [15:0] host_psel;
  logic [15:0] phy_pen;
  logic [15:0] phy_psel;
  logic [1:0] supply_flags;
  logic [6:0] bit_dur;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  pcsr_pkg::pcsr_state_t state;

  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire sel_drive = hit(paddr, `PCSR_IDX_DRIVE);
  wire sel_hpen = hit(paddr, `PCSR_IDX_HOST_PEN);
  wire sel_hpsel = hit(paddr, `PCSR_IDX_HOST_PSEL);
  wire sel_ppen = hit(paddr, `PCSR_IDX_PHY_PEN);
  wire sel_ppsel = hit(paddr, `PCSR_IDX_PHY_PSEL);
  wire sel_sup = hit(paddr, `PCSR_IDX_SUPPLY);
  wire sel_bd = hit(paddr, `PCSR_IDX_BIT_DUR);
  wire sel_ctrl = hit(paddr, `PCSR_IDX_CTRL);
  wire sel_istat = hit(paddr, `PCSR_IDX_IRQ_STAT);
  wire sel_imask = hit(paddr, `PCSR_IDX_IRQ_MASK);
  wire mapped = sel_drive | sel_hpen | sel_hpsel | sel_ppen | sel_ppsel |
                sel_sup | sel_bd | sel_ctrl | sel_istat | sel_imask;
  wire in_config = (state == pcsr_pkg::PCSR_CONFIG);
  wire bd_write_ok = wr && sel_bd && in_config;
  wire bd_refused = wr && sel_bd && !in_config;
  wire ctrl_wr = wr && sel_ctrl;
  wire cfg_enter = ctrl_wr && pwdata[`PCSR_CTRL_CONFIG_BIT] && !in_config;
  wire [1:0] irq_events = {cfg_enter, bd_refused};

  // Per-register write strobes, one decode shared by every field
  wire wr_drive = wr && sel_drive;
  wire wr_hpen = wr && sel_hpen;
  wire wr_hpsel = wr && sel_hpsel;
  wire wr_ppen = wr && sel_ppen;
  wire wr_ppsel = wr && sel_ppsel;
  wire wr_imask = wr && sel_imask;

  // Read words per register; reserved bits come back as zero
  wire [31:0] rd_drive = word16(drive_reg);
  wire [31:0] rd_hpen = word16(host_pen);
  wire [31:0] rd_hpsel = word16(host_psel);
  wire [31:0] rd_ppen = word16(phy_pen);
  wire [31:0] rd_ppsel = word16(phy_psel);
  wire [31:0] rd_sup = {30'h0, supply_flags};
  wire [31:0] rd_bd = {25'h0, bit_dur};
  wire [31:0] rd_ctrl = {31'h0, in_config};
  wire [31:0] rd_istat = {30'h0, irq_stat};
  wire [31:0] rd_imask = {30'h0, irq_mask};
  wire [31:0] rd_mux =
    sel_drive ? rd_drive :
    sel_hpen ? rd_hpen :
    sel_hpsel ? rd_hpsel :
    sel_ppen ? rd_ppen :
    sel_ppsel ? rd_ppsel :
    sel_sup ? rd_sup :
    sel_bd ? rd_bd :
    sel_ctrl ? rd_ctrl :
    sel_istat ? rd_istat :
    sel_imask ? rd_imask : 32'h0000_0000;

  // One wait state; held off entirely during internal reset
  wire next_pready = psel && penable && !pready && !int_rst;
  wire next_pslverr = next_pready && !mapped;
  wire [31:0] next_prdata =
    (next_pready && !pwrite) ? rd_mux : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (int_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_pslverr;
    end
  end

  // Read data only stands with pready, so idle bus cycles read zero
  always_ff @(posedge clk) begin
    if (int_rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // Pad configuration registers, one short block each
  always_ff @(posedge clk) begin
    if (int_rst) begin
      drive_reg <= `PCSR_PAD_RESET;
    end else if (wr_drive) begin
      drive_reg <= phy_field(pwdata);
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      host_pen <= `PCSR_PAD_RESET;
    end else if (wr_hpen) begin
      host_pen <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      host_psel <= `PCSR_PAD_RESET;
    end else if (wr_hpsel) begin
      host_psel <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      phy_pen <= `PCSR_PAD_RESET;
    end else if (wr_ppen) begin
      phy_pen <= phy_field(pwdata);
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      phy_psel <= `PCSR_PAD_RESET;
    end else if (wr_ppsel) begin
      phy_psel <= phy_field(pwdata);
    end
  end

  // Configuration state; hard or internal reset lands in configuration
  always_ff @(posedge clk) begin
    if (int_rst) begin
      state <= pcsr_pkg::PCSR_CONFIG;
    end else if (ctrl_wr) begin
      unique case (pwdata[`PCSR_CTRL_CONFIG_BIT])
        1'b1: state <= pcsr_pkg::PCSR_CONFIG;
        1'b0: state <= pcsr_pkg::PCSR_NORMAL;
      endcase
    end
  end

  // Bit duration; kept defined after reset for simulation clarity
  always_ff @(posedge clk) begin
    if (int_rst) begin
      bit_dur <= `PCSR_BIT_DUR_RESET;
    end else if (bd_write_ok) begin
      bit_dur <= pwdata[6:0];
    end
  end

  // Supply flags survive the internal reset they cause; set beats clear
  wire sup_clr = rd && sel_sup;
  wire [1:0] next_supply = (sup_clr ? 2'b00 : supply_flags) |
                           {evt_sync[1], evt_sync[0]};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      supply_flags <= 2'b00;
    end else begin
      supply_flags <= next_supply;
    end
  end

  // Interrupt status: only block events, never supply flags
  wire istat_clr = rd && sel_istat;
  wire [1:0] next_istat = (istat_clr ? 2'b00 : irq_stat) | irq_events;
  wire next_irq_n = !(|(next_istat & irq_mask));

  always_ff @(posedge clk) begin
    if (int_rst) begin
      irq_stat <= 2'b00;
    end else begin
      irq_stat <= next_istat;
    end
  end

  always_ff @(posedge clk) begin
    if (int_rst) begin
      irq_mask <= 2'b00;
    end else if (wr_imask) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // Mask write reaches the interrupt level one cycle after the mask register loads
  always_ff @(posedge clk) begin
    if (int_rst) begin
      controller_irq_n <= 1'b1;
    end else begin
      controller_irq_n <= next_irq_n;
    end
  end

  // Per-pin pull decode; a direction bit acts only where enabled
  wire [HOST_PINS-1:0] next_host_up;
  wire [HOST_PINS-1:0] next_host_down;
  wire [PHY_PINS-1:0] next_phy_up;
  wire [PHY_PINS-1:0] next_phy_down;
  genvar pin;
  generate
    for (pin = 0; pin < HOST_PINS; pin++) begin : g_host_pad
      assign next_host_up[pin] =
        pull_up_of(host_pen[pin], host_psel[pin]);
      assign next_host_down[pin] =
        pull_down_of(host_pen[pin], host_psel[pin]);
    end
    for (pin = 0; pin < PHY_PINS; pin++) begin : g_phy_pad
      assign next_phy_up[pin] =
        pull_up_of(phy_pen[pin], phy_psel[pin]);
      assign next_phy_down[pin] =
        pull_down_of(phy_pen[pin], phy_psel[pin]);
    end
  endgenerate

  // Pad control outputs, registered one cycle after the fields so that
  // every top-level output comes from a flop
  always_ff @(posedge clk) begin
    if (int_rst) begin
      phy_drive_partial <= '0;
      host_pull_up <= '0;
      host_pull_down <= '0;
      phy_pull_up <= '0;
      phy_pull_down <= '0;
      microticks_per_bit <= `PCSR_BIT_DUR_RESET;
      config_state <= 1'b1;
    end else begin
      phy_drive_partial <= drive_reg[PHY_PINS-1:0];
      host_pull_up <= next_host_up;
      host_pull_down <= next_host_down;
      phy_pull_up <= next_phy_up;
      phy_pull_down <= next_phy_down;
      microticks_per_bit <= bit_dur;
      config_state <= in_config;
    end
  end

  // Reset indication lags the internal reset by one cycle
  wire next_int_reset = evt_any || hold_busy;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_reset_active <= 1'b1;
    end else begin
      int_reset_active <= next_int_reset;
    end
  end

endmodule : pcsr_regs

/* File: dv/pcsr_regs_props.sv */
// Property checker for the pad config and supply status bank.
// Assumes it is bound to the register bank's top-level ports.
`timescale 1ns/1ps
module pcsr_regs_props #(
  parameter int HOST_PINS = 16, // host-side pads
  parameter int PHY_PINS = 4 // transceiver pads
) (
  input wire logic clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic controller_irq_n, // interrupt
  input wire logic int_reset_active, // internal reset
  input wire logic config_state, // config state
  input wire logic [PHY_PINS-1:0] phy_drive_partial, // drive
  input wire logic [HOST_PINS-1:0] host_pull_up, // host up
  input wire logic [HOST_PINS-1:0] host_pull_down, // host down
  input wire logic [PHY_PINS-1:0] phy_pull_up, // phy up
  input wire logic [PHY_PINS-1:0] phy_pull_down // phy down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic rd_ok = pready && !pwrite;
  wire logic pads_off = !phy_drive_partial && !host_pull_up &&
    !host_pull_down && !phy_pull_up && !phy_pull_down && config_state;
  AST_HOST_PULL: assert property (
    (host_pull_up & host_pull_down) == '0) else $error("host pull clash");
  AST_PHY_PULL: assert property (
    (phy_pull_up & phy_pull_down) == '0) else $error("phy pull clash");
  AST_RST_PADS: assert property (
    $rose(rst_b) |-> pads_off) else $error("pads not reset");
  AST_INT_RST: assert property (
    $fell(int_reset_active) |-> pads_off) else $error("int reset lost");
  AST_RDY_ACCESS: assert property (
    pready |-> psel && penable) else $error("ready outside access");
  AST_RDY_STALL: assert property (
    int_reset_active |-> !pready) else $error("ready during reset");
  AST_SUP_RSVD: assert property (
    rd_ok && paddr == 12'h298 |-> prdata[31:2] == '0)
    else $error("supply reserved bits set");
  AST_BD_RSVD: assert property (
    rd_ok && paddr == 12'h2A0 |-> prdata[31:7] == '0)
    else $error("duration reserved bits set");
  AST_DRV_RSVD: assert property (
    rd_ok && paddr == 12'h270 |-> prdata[31:4] == '0)
    else $error("drive reserved bits set");
  AST_IRQ_IDLE: assert property (
    int_reset_active |-> ##1 controller_irq_n) else $error("irq in reset");
endmodule : pcsr_regs_props

/* File: dv/pcsr_host_model.sv */
// APB host model that drives the register bank.
// Assumes one xfer call at a time, entered right after a clock edge.
`timescale 1ns/1ps
module pcsr_host_model (
  input wire logic clk, // bus clock
  input wire logic pready, // slave ready
  input wire logic [31:0] prdata, // slave read data
  input wire logic pslverr, // slave error
  output logic psel = 1'b0, // select
  output logic penable = 1'b0, // enable
  output logic pwrite = 1'b0, // direction
  output logic [11:0] paddr = 12'h000, // byte address
  output logic [31:0] pwdata = 32'h00000000 // write data
);
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output bit ok);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    ok = 1'b0;
    // No latency assumed; waits out any internal reset
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge clk);
      ok = (pready === 1'b1);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep looking valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : pcsr_host_model

/* File: dv/pcsr_regs_tb.sv */
// Self-checking bench for the pad config and supply status bank.
// Assumes the APB host model and the property checker.
`timescale 1ns/1ps
`include "pcsr_defines.svh"
`define CHK(a, b) chk_val(32'(a), 32'(b));
module pcsr_regs_tb;
  localparam int D = `PCSR_IDX_DRIVE;
  localparam int HE = `PCSR_IDX_HOST_PEN;
  localparam int HS = `PCSR_IDX_HOST_PSEL;
  localparam int PE = `PCSR_IDX_PHY_PEN;
  localparam int PS = `PCSR_IDX_PHY_PSEL;
  localparam int SU = `PCSR_IDX_SUPPLY;
  localparam int BD = `PCSR_IDX_BIT_DUR;
  localparam int CT = `PCSR_IDX_CTRL;
  localparam int IM = `PCSR_IDX_IRQ_MASK;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] evt = 2'b00;
  logic psel, penable, pwrite, pready, pslverr, controller_irq_n;
  logic int_reset_active, config_state, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] microticks_per_bit;
  logic [3:0] phy_drive_partial, phy_pull_up, phy_pull_down;
  logic [15:0] host_pull_up, host_pull_down;
  int error_cnt = 0;
  int checked = 0;
  int seed;
  int mdl[int];
  int msk[int] = '{D: 32'hF, HE: 32'hFFFF, HS: 32'hFFFF, PE: 32'hF,
    PS: 32'hF, SU: 32'h3, BD: 32'h7F, CT: 32'h1, IM: 32'h3};
  pcsr_regs dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .low_volt_evt(evt[1]),
    .power_on_evt(evt[0]), .controller_irq_n, .int_reset_active,
    .config_state, .microticks_per_bit, .phy_drive_partial, .host_pull_up,
    .host_pull_down, .phy_pull_up, .phy_pull_down);
  pcsr_host_model host (.clk, .pready, .prdata, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  always #12.5 clk = ~clk;
  task automatic chk_val(input logic [31:0] a, input logic [31:0] b);
    checked++;
    if (a !== b) begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, a, b);
    end
  endtask : chk_val
  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic acc(input logic w, input int i, input logic [31:0] d);
    bit ok;
    @(posedge clk);
    host.xfer(w, 12'(i * 4), d, q, err, ok);
    if (!ok) begin
      error_cnt++;
      wrap_up();
    end
  endtask : acc
  task automatic wr(input int i, input logic [31:0] d);
    acc(1'b1, i, d);
    // Duration write outside configuration leaves the value alone
    if (!(i == BD && mdl[CT] == 0)) mdl[i] = d & msk[i];
  endtask : wr
  task automatic rd(input int i);
    acc(1'b0, i, 32'h0);
    `CHK(q, msk.exists(i) ? mdl[i] : 0)
    `CHK(err, !msk.exists(i))
    if (i == SU) mdl[i] = 0;
  endtask : rd
  task automatic pads();
    @(posedge clk);
    `CHK(phy_drive_partial, mdl[D])
    `CHK(host_pull_up, mdl[HE] & mdl[HS])
    `CHK(host_pull_down, mdl[HE] & ~mdl[HS])
    `CHK(phy_pull_up, mdl[PE] & mdl[PS])
    `CHK(phy_pull_down, mdl[PE] & ~mdl[PS])
    `CHK(microticks_per_bit, mdl[BD])
    `CHK(config_state, mdl[CT])
  endtask : pads
  task automatic rst_mdl();
    foreach (msk[i]) if (i != SU) mdl[i] = (i == CT);
  endtask : rst_mdl
  task automatic ev(input int b);
    evt <= 2'(1 << b);
    repeat (3) @(posedge clk);
    evt <= 2'b00;
    repeat (4) @(posedge clk);
    `CHK(int_reset_active, 1)
    rst_mdl();
    mdl[SU] = mdl[SU] | (1 << b);
  endtask : ev
  initial begin
    seed = 32'hF3D5B41D;
    mdl[SU] = 0;
    rst_mdl();
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (msk[i]) rd(i);
    repeat (6) begin
      foreach (msk[i]) if (i != SU && i != CT) begin
        wr(i, $random(seed));
        rd(i);
      end
      pads();
    end
    wr(IM, 32'h0);
    wr(CT, 32'h0);
    rd(CT);
    wr(BD, 32'h55);
    rd(BD);
    `CHK(controller_irq_n, 1)
    wr(IM, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(controller_irq_n, 0)
    acc(1'b0, `PCSR_IDX_IRQ_STAT, 32'h0);
    `CHK(q & 1, 1)
    repeat (2) @(posedge clk);
    `CHK(controller_irq_n, 1)
    wr(CT, 32'h1);
    wr(BD, 32'h2A);
    rd(BD);
    rd(12'hFF);
    for (int b = 0; b < 2; b++) begin
      wr(IM, 32'h3);
      ev(b);
      rd(SU);
      `CHK(controller_irq_n, 1)
      pads();
      rd(CT);
      rd(SU);
    end
    wrap_up();
  end
endmodule : pcsr_regs_tb
bind pcsr_regs pcsr_regs_props #(.HOST_PINS(HOST_PINS), .PHY_PINS(PHY_PINS))
  props (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .controller_irq_n, .int_reset_active, .config_state, .phy_drive_partial,
  .host_pull_up, .host_pull_down, .phy_pull_up, .phy_pull_down);
